// >>> rtl/plcsr_top.v
// link control (upper byte and retrain bit) and link status register bank of one switch port
// assumes all link-side inputs come from same-clock physical/data link logic
`timescale 1ns/1ps
`default_nettype none
`include "plcsr_regs.vh"

module plcsr_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // port configuration
  input  wire        port_upstream_i,
  input  wire        bw_notify_capable_i,
  input  wire        dl_active_capable_i,
  input  wire        common_clock_mode_i,
  input  wire [5:0]  max_width_setting_i,
  // physical layer
  input  wire        ltssm_cfg_rec_i,
  input  wire        link_trained_i,
  input  wire [3:0]  phy_speed_i,
  input  wire [5:0]  phy_width_i,
  input  wire        phy_fix_change_i,
  input  wire        phy_auto_change_i,
  input  wire        remote_change_i,
  input  wire        remote_auto_i,
  // data link layer
  input  wire        dl_active_i,
  input  wire        dl_down_i,
  // outputs to link and interrupt logic
  output reg         retrain_request_o,
  output reg         bw_mgmt_irq_o,
  output reg         auto_bw_irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // widths that this port can train to
  function width_supported;
    input [5:0] w;
    begin
      case (w)
        `PLCSR_WID_X1: width_supported = 1'b1;
        `PLCSR_WID_X2: width_supported = 1'b1;
        `PLCSR_WID_X4: width_supported = 1'b1;
        `PLCSR_WID_X8: width_supported = 1'b1;
        default:       width_supported = 1'b0;
      endcase
    end
  endfunction

  // legal width code of the field
  function width_legal;
    input [5:0] w;
    begin
      case (w)
        `PLCSR_WID_X12: width_legal = 1'b1;
        `PLCSR_WID_X16: width_legal = 1'b1;
        `PLCSR_WID_X32: width_legal = 1'b1;
        default:        width_legal = width_supported(w);
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  reg        bw_mgmt_irq_enable_q;
  reg        auto_bw_irq_enable_q;
  reg        bw_mgmt_status_q;
  reg        auto_bw_status_q;
  reg [3:0]  current_speed_q;
  reg [5:0]  negotiated_width_q;
  reg        retrain_wait_q;
  reg        retrain_busy_q;
  reg        retrain_dl_down_q;
  reg        cfg_rec_q;
  reg        slot_clock_q;
  reg        strap_taken_q;
  reg        unlock_q;

  wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr       = req & wb_we_i;
  wire [9:0] idx      = wb_adr_i[11:2];
  wire       hit_ctl  = (idx == `PLCSR_IDX_LCTL);
  wire       hit_sts  = (idx == `PLCSR_IDX_LSTS);
  wire       hit_lock = (idx == `PLCSR_IDX_LOCK);
  wire       wr_hi    = wr & wb_sel_i[`PLCSR_SEL_HI];
  wire       wr_lo    = wr & wb_sel_i[`PLCSR_SEL_LO];

  wire       bw_cap   = bw_notify_capable_i & ~port_upstream_i;
  wire       downstream = ~port_upstream_i;

  wire       retrain_wr = wr_lo & hit_ctl & wb_dat_i[`PLCSR_CTL_RETRAIN];

  // leaving config/recovery ends a retrain
  wire       cfg_rec_exit = cfg_rec_q & ~ltssm_cfg_rec_i;

  // retrain completed, no DL_Down on the way
  wire       retrain_done = retrain_busy_q & cfg_rec_exit & ~retrain_dl_down_q & ~dl_down_i;

  wire       bw_evt   = retrain_done | (phy_fix_change_i & ~dl_down_i) |
                        (remote_change_i & ~remote_auto_i);

  wire       abw_evt  = (phy_auto_change_i & ~dl_down_i) |
                        (remote_change_i & remote_auto_i);

  wire       bws_clr  = wr_hi & hit_sts & wb_dat_i[`PLCSR_STS_BWS];
  wire       abws_clr = wr_hi & hit_sts & wb_dat_i[`PLCSR_STS_ABWS];

  //////////////////////////////////////////////////////////////////////////////
  // wishbone handshake: one answer per taken request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // one-cycle pulse towards the LTSSM
  always @(posedge clk_i) begin
    if (rst_i) begin
      retrain_request_o <= 1'b0;
    end else begin
      retrain_request_o <= retrain_wr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bandwidth interrupt enables
  always @(posedge clk_i) begin
    if (rst_i) begin
      bw_mgmt_irq_enable_q <= 1'b0;
      auto_bw_irq_enable_q <= 1'b0;
    end else if (wr_hi && hit_ctl) begin
      // enables forced to zero without capability
      bw_mgmt_irq_enable_q <= wb_dat_i[`PLCSR_CTL_BWIE] & bw_cap;
      auto_bw_irq_enable_q <= wb_dat_i[`PLCSR_CTL_ABWIE] & bw_cap;
    end else if (!bw_cap) begin
      bw_mgmt_irq_enable_q <= 1'b0;
      auto_bw_irq_enable_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lock register guarding the slot clock bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      unlock_q <= 1'b0;
    end else if (wr_lo && hit_lock) begin
      unlock_q <= wb_dat_i[`PLCSR_LOCK_UNLOCK];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky bandwidth flags; a set in the clearing cycle wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      bw_mgmt_status_q <= 1'b0;
    end else if (!bw_cap) begin
      bw_mgmt_status_q <= 1'b0;
    end else begin
      bw_mgmt_status_q <= bw_evt | (bw_mgmt_status_q & ~bws_clr);
    end
  end

  // autonomous flag, same set-wins policy
  always @(posedge clk_i) begin
    if (rst_i) begin
      auto_bw_status_q <= 1'b0;
    end else if (!bw_cap) begin
      auto_bw_status_q <= 1'b0;
    end else begin
      auto_bw_status_q <= abw_evt | (auto_bw_status_q & ~abws_clr);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // retrain tracking
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_rec_q <= 1'b0;
    end else begin
      cfg_rec_q <= ltssm_cfg_rec_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      retrain_wait_q <= 1'b0;
    end else if (retrain_wait_q && ltssm_cfg_rec_i) begin
      retrain_wait_q <= 1'b0;
    end else if (retrain_wr) begin
      retrain_wait_q <= 1'b1;
    end
  end

  // a retrain stays open until the LTSSM leaves config/recovery
  always @(posedge clk_i) begin
    if (rst_i) begin
      retrain_busy_q    <= 1'b0;
      retrain_dl_down_q <= 1'b0;
    end else begin
      if (retrain_wr) begin
        retrain_busy_q    <= 1'b1;
        retrain_dl_down_q <= 1'b0;
      end else if (cfg_rec_exit && !retrain_wait_q) begin
        retrain_busy_q    <= 1'b0;
        retrain_dl_down_q <= 1'b0;
      end else if (retrain_busy_q && dl_down_i) begin
        retrain_dl_down_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // speed, width and clock configuration
  always @(posedge clk_i) begin
    if (rst_i) begin
      current_speed_q <= `PLCSR_SPD_RESET;
    end else begin
      // only defined codes accepted; reserved codes hold
      if (phy_speed_i == `PLCSR_SPD_GEN1 || phy_speed_i == `PLCSR_SPD_GEN2) begin
        current_speed_q <= phy_speed_i;
      end
    end
  end

  // negotiated width
  always @(posedge clk_i) begin
    if (rst_i) begin
      negotiated_width_q <= `PLCSR_WID_NONE;
    end else begin
      if (!width_supported(max_width_setting_i)) begin
        negotiated_width_q <= max_width_setting_i;
      end else if (!link_trained_i) begin
        negotiated_width_q <= `PLCSR_WID_NONE;
      end else if (width_legal(phy_width_i)) begin
        negotiated_width_q <= phy_width_i;
      end
    end
  end

  // slot clock bit; strap is only meaningful right after reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      slot_clock_q  <= 1'b0;
      strap_taken_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
      if (!strap_taken_q) begin
        slot_clock_q <= common_clock_mode_i;
      end else if (wr_hi && hit_sts && unlock_q) begin
        slot_clock_q <= wb_dat_i[`PLCSR_STS_SCLK];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data and interrupt requests
  reg [15:0] ctl_rd;
  reg [15:0] sts_rd;
  always @* begin
    ctl_rd = 16'h0000;
    sts_rd = 16'h0000;
    ctl_rd[`PLCSR_CTL_CLKPM]   = 1'b0;
    ctl_rd[`PLCSR_CTL_AWD]     = 1'b0;
    ctl_rd[`PLCSR_CTL_RETRAIN] = 1'b0;
    ctl_rd[`PLCSR_CTL_BWIE]    = bw_mgmt_irq_enable_q;
    ctl_rd[`PLCSR_CTL_ABWIE]   = auto_bw_irq_enable_q;
    sts_rd[`PLCSR_STS_SPD_HI:`PLCSR_STS_SPD_LO] = current_speed_q;
    sts_rd[`PLCSR_STS_WID_HI:`PLCSR_STS_WID_LO] = negotiated_width_q;
    sts_rd[`PLCSR_STS_TRAIN] = downstream & (ltssm_cfg_rec_i | retrain_wait_q);
    sts_rd[`PLCSR_STS_SCLK]  = slot_clock_q;
    sts_rd[`PLCSR_STS_DLA]   = dl_active_i & dl_active_capable_i;
    sts_rd[`PLCSR_STS_BWS]   = bw_mgmt_status_q;
    sts_rd[`PLCSR_STS_ABWS]  = auto_bw_status_q;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      // unmapped addresses answer with zero
      if (req && !wb_we_i && hit_ctl) begin
        wb_dat_o <= {16'h0000, ctl_rd};
      end else if (req && !wb_we_i && hit_sts) begin
        wb_dat_o <= {16'h0000, sts_rd};
      end else if (req && !wb_we_i && hit_lock) begin
        wb_dat_o <= {31'h00000000, unlock_q};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered so the requests cannot glitch; costs one cycle of lag
  always @(posedge clk_i) begin
    if (rst_i) begin
      bw_mgmt_irq_o <= 1'b0;
      auto_bw_irq_o <= 1'b0;
    end else begin
      bw_mgmt_irq_o <= bw_mgmt_status_q & bw_mgmt_irq_enable_q;
      auto_bw_irq_o <= auto_bw_status_q & auto_bw_irq_enable_q;
    end
  end

endmodule // plcsr_top
`default_nettype wire

// >>> rtl/plcsr_regs.vh
// register indices, field positions and reset values of the link control/status bank
// assumes byte address = 4 * index on a 32-bit classic Wishbone bus
`ifndef PLCSR_REGS_VH
`define PLCSR_REGS_VH

// register indices (word address = wb_adr_i[11:2])
`define PLCSR_IDX_LCTL      10'h050
`define PLCSR_IDX_LSTS      10'h052
`define PLCSR_IDX_LOCK      10'h060
`define PLCSR_IDX_W         10

// link_control fields
`define PLCSR_CTL_RETRAIN   5
`define PLCSR_CTL_CLKPM     8
`define PLCSR_CTL_AWD       9
`define PLCSR_CTL_BWIE      10
`define PLCSR_CTL_ABWIE     11

// link_status fields
`define PLCSR_STS_SPD_LO    0
`define PLCSR_STS_SPD_HI    3
`define PLCSR_STS_WID_LO    4
`define PLCSR_STS_WID_HI    9
`define PLCSR_STS_TRAIN     11
`define PLCSR_STS_SCLK      12
`define PLCSR_STS_DLA       13
`define PLCSR_STS_BWS       14
`define PLCSR_STS_ABWS      15

// lock register field
`define PLCSR_LOCK_UNLOCK   0

// byte lanes
`define PLCSR_SEL_LO        0
`define PLCSR_SEL_HI        1

// speed codes
`define PLCSR_SPD_RESET     4'h1
`define PLCSR_SPD_GEN1      4'h1
`define PLCSR_SPD_GEN2      4'h2

// width codes
`define PLCSR_WID_NONE      6'h00
`define PLCSR_WID_X1        6'h01
`define PLCSR_WID_X2        6'h02
`define PLCSR_WID_X4        6'h04
`define PLCSR_WID_X8        6'h08
`define PLCSR_WID_X12       6'h0C
`define PLCSR_WID_X16       6'h10
`define PLCSR_WID_X32       6'h20

`endif

// >>> verif/plcsr_properties.sv
// assertions on the bus answer, control/status reads and retrain pulse
// assumes one clock, rst_i synchronous active high
`timescale 1ns/1ps
`default_nettype none
`include "plcsr_regs.vh"
module plcsr_chk (
  // clock, reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // link side
  input wire logic        port_upstream_i,
  input wire logic        dl_active_capable_i,
  input wire logic        ltssm_cfg_rec_i,
  input wire logic        retrain_request_o,
  input wire logic        bw_mgmt_irq_o,
  input wire logic        auto_bw_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [9:0] ix = wb_adr_i[11:2];
  wire logic rd = wb_ack_o && !wb_we_i;
  wire logic st = rd && ix == `PLCSR_IDX_LSTS;
  wire logic ct = rd && ix == `PLCSR_IDX_LCTL;
  wire logic rt = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[5]
                  && ix == `PLCSR_IDX_LCTL;
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a one cycle answer");
  property p_ctl; ct |-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[9:8] == 2'h0 && !wb_dat_o[5]; endproperty
  a_ctl: assert property (p_ctl) else $error("control fixed bits not zero");
  property p_up; port_upstream_i[*4] ##0 rd |-> (wb_dat_o[15:10] & (st ? 6'h32 : ct ? 6'h3F : 6'h00)) == 6'h00; endproperty
  a_up: assert property (p_up) else $error("upstream bandwidth bits set");
  property p_irq; port_upstream_i[*4] |-> !bw_mgmt_irq_o && !auto_bw_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("upstream irq raised");
  property p_dla; (!dl_active_capable_i)[*2] ##0 st |-> !wb_dat_o[13]; endproperty
  a_dla: assert property (p_dla) else $error("link active without capability");
  property p_trn; (ltssm_cfg_rec_i && !port_upstream_i)[*2] ##1 st |-> wb_dat_o[11]; endproperty
  a_trn: assert property (p_trn) else $error("training flag low in recovery");
  property p_rt; rt |=> retrain_request_o ##1 !retrain_request_o; endproperty
  a_rt: assert property (p_rt) else $error("retrain pulse missing");
  property p_rtc; retrain_request_o |-> $past(rt); endproperty
  a_rtc: assert property (p_rtc) else $error("retrain pulse without write");
  c_rt: cover property (retrain_request_o);
  c_bw: cover property (bw_mgmt_irq_o);
  c_ab: cover property (st && wb_dat_o[15]);
endmodule // plcsr_chk
`default_nettype wire

// >>> verif/plcsr_link_model.sv
// link stand-in: a retrain pulse sends it through one recovery pass
// assumes port clock; slow_i makes it wait before the pass starts
`timescale 1ns/1ps
`default_nettype none
module plcsr_link_model (
  // clock, reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // link
  input  wire logic slow_i,
  input  wire logic retrain_request_i,
  output wire logic ltssm_cfg_rec_o
);
  logic [4:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 5'h00;
    end else if (retrain_request_i) begin
      cnt_q <= slow_i ? 5'h0E : 5'h06;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
  // pass is the last six counts
  assign ltssm_cfg_rec_o = cnt_q != 5'h00 && cnt_q < 5'h07;
endmodule // plcsr_link_model
`default_nettype wire

// >>> verif/plcsr_top_bench.sv
// bench: bus tasks, link events, expected register values
// assumes the link model answers retrain pulses; checker bound at foot
`timescale 1ns/1ps
`default_nettype none
`include "plcsr_regs.vh"
module plcsr_top_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0, sp = 4'h1;
  logic [31:0] dat = 32'h0, dat_o;
  logic        ack, rtr, ibw, iab, ltr, fx = 1'b0, au = 1'b0, rc = 1'b0, ra = 1'b0;
  logic        up = 1'b0, bwc = 1'b1, dlc = 1'b1, trn = 1'b1, act = 1'b1, dn = 1'b0, slow = 1'b0;
  logic        ccm = 1'b1;
  logic [5:0]  mw = 6'h04, wd = 6'h04, ws [3] = '{6'h0C, 6'h10, 6'h20};
  logic [15:0] q;
  logic [9:0]  ci = `PLCSR_IDX_LCTL, si = `PLCSR_IDX_LSTS;
  integer      mismatches = 0, cmp_count = 0, i;
  always #10 clk_i = ~clk_i;
  plcsr_top i_plcsr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .port_upstream_i(up), .bw_notify_capable_i(bwc),
    .dl_active_capable_i(dlc), .common_clock_mode_i(ccm), .max_width_setting_i(mw),
    .ltssm_cfg_rec_i(ltr), .link_trained_i(trn), .phy_speed_i(sp), .phy_width_i(wd),
    .phy_fix_change_i(fx), .phy_auto_change_i(au), .remote_change_i(rc),
    .remote_auto_i(ra), .dl_active_i(act), .dl_down_i(dn), .retrain_request_o(rtr),
    .bw_mgmt_irq_o(ibw), .auto_bw_irq_o(iab));
  plcsr_link_model i_plcsr_link_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .retrain_request_i(rtr), .ltssm_cfg_rec_o(ltr));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until ack is sampled, then released
  task automatic bus(input logic [9:0] ix, input logic w, input logic [15:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    sel <= s;
    dat <= {16'h0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [9:0] ix, input logic [15:0] m, input logic [15:0] e);
    bus(ix, 1'b0, 16'h0000, 4'h3);
    chk(nm, e, q & m);
  endtask
  task automatic pulse(input integer k);
    @(posedge clk_i);
    fx <= k == 0;
    au <= k == 1;
    rc <= k > 1;
    ra <= k == 3;
    @(posedge clk_i);
    {fx, au, rc, ra} <= 4'h0;
    repeat (3) @(posedge clk_i);
  endtask
  // watchdog, well past the longest sequence
  initial begin
    #200000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd("ctl", ci, 16'hFFFF, 16'h0000);
    rd("sts", si, 16'hFFFF, 16'h3041);
    rd("unmapped", 10'h3FF, 16'hFFFF, 16'h0000);
    mw <= 6'h08;
    for (i = 0; i < 8; i++) begin
      sp <= i[0] ? 4'h2 : 4'h1;
      wd <= 6'h01 << (i / 2);
      rd("spd wid", si, 16'h03FF, {6'h00, 6'h01 << (i / 2), i[0] ? 4'h2 : 4'h1});
    end
    wd <= 6'h04;
    for (i = 0; i < 3; i++) begin
      mw <= ws[i];
      rd("wid", si, 16'h03F0, {6'h00, ws[i], 4'h0});
    end
    mw <= 6'h04;
    trn <= 1'b0;
    rd("wid", si, 16'h03F0, 16'h0000);
    trn <= 1'b1;
    slow <= 1'b1;
    bus(ci, 1'b1, 16'h0C20, 4'h3);
    rd("train", si, 16'h0800, 16'h0800);
    repeat (24) @(posedge clk_i);
    rd("sts", si, 16'hC800, 16'h4000);
    rd("ctl", ci, 16'hFFFF, 16'h0C00);
    chk("bw irq", 16'h0001, {15'h0, ibw});
    slow <= 1'b0;
    bus(ci, 1'b1, 16'h0C20, 4'h3);
    rd("train", si, 16'h0800, 16'h0800);
    rd("train", si, 16'h0800, 16'h0800);
    repeat (12) @(posedge clk_i);
    bus(si, 1'b1, 16'hC000, 4'h2);
    rd("sts", si, 16'hC800, 16'h0000);
    chk("bw irq", 16'h0000, {15'h0, ibw});
    for (i = 0; i < 4; i++) begin
      pulse(i);
      rd("event", si, 16'hC000, i[0] ? 16'h8000 : 16'h4000);
      chk("irqs", {14'h0, i[0], !i[0]}, {14'h0, iab, ibw});
      bus(si, 1'b1, 16'hC000, 4'h2);
    end
    pulse(1);
    bus(ci, 1'b1, 16'h0000, 4'h2);
    rd("kept", si, 16'h8000, 16'h8000);
    chk("auto irq", 16'h0000, {15'h0, iab});
    bus(si, 1'b1, 16'h8000, 4'h2);
    dn <= 1'b1;
    pulse(0);
    rd("dl down", si, 16'h4000, 16'h0000);
    dn <= 1'b0;
    for (i = 0; i < 2; i++) begin
      up <= i[0];
      bwc <= i[0];
      bus(ci, 1'b1, 16'h0C00, 4'h2);
      pulse(0);
      pulse(1);
      rd("no bw", si, 16'hC000, 16'h0000);
      rd("no en", ci, 16'h0C00, 16'h0000);
      chk("irqs", 16'h0000, {14'h0, iab, ibw});
    end
    bus(ci, 1'b1, 16'h0020, 4'h1);
    rd("train", si, 16'h0800, 16'h0000);
    repeat (12) @(posedge clk_i);
    up <= 1'b0;
    bwc <= 1'b1;
    dlc <= 1'b0;
    rd("active", si, 16'h2000, 16'h0000);
    dlc <= 1'b1;
    act <= 1'b0;
    rd("active", si, 16'h2000, 16'h0000);
    bus(si, 1'b1, 16'h0000, 4'h2);
    rd("slot clk", si, 16'h1000, 16'h1000);
    bus(`PLCSR_IDX_LOCK, 1'b1, 16'h0001, 4'h1);
    bus(si, 1'b1, 16'h0000, 4'h2);
    rd("slot clk", si, 16'h1000, 16'h0000);
    bus(si, 1'b1, 16'h1000, 4'h2);
    ccm <= 1'b0;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("reset sts", si, 16'hF000, 16'h0000);
    rd("reset ctl", ci, 16'hFFFF, 16'h0000);
    tally_and_finish;
  end
endmodule // plcsr_top_bench
bind plcsr_top plcsr_chk i_plcsr_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_upstream_i(port_upstream_i),
  .dl_active_capable_i(dl_active_capable_i), .ltssm_cfg_rec_i(ltssm_cfg_rec_i),
  .retrain_request_o(retrain_request_o), .bw_mgmt_irq_o(bw_mgmt_irq_o),
  .auto_bw_irq_o(auto_bw_irq_o));
`default_nettype wire
